// ### hw/port_chk_pkg.sv
// constants, types and layouts for the port access checker
package port_chk_pkg;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_FLAGS  = 8'h04;
  localparam logic [7:0] OFF_TBASE  = 8'h08;
  localparam logic [7:0] OFF_TLIMIT = 8'h0c;
  localparam logic [7:0] OFF_MAPB   = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  localparam int CTRL_LEGACY_BIT = 0;
  localparam int FLAG_IF_BIT     = 9;
  localparam int FLAG_THR_LO     = 12;
  localparam int FLAG_THR_HI     = 13;
  localparam int STAT_CNT_LO     = 16;

  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST  = 32'h0000_0002;
  localparam logic [31:0] TBASE_RST  = 32'h0000_0000;
  localparam logic [31:0] TLIMIT_RST = 32'h0000_0067;
  localparam logic [15:0] MAPB_RST   = 16'h0068;

  localparam logic [1:0] PRIV_TOP     = 2'h0;
  localparam logic [7:0] BYTE_ALL_SET = 8'hff;

  typedef enum logic [3:0] {
    OP_LOAD_ONE,
    OP_LOAD_BLOCK,
    OP_STORE_ONE,
    OP_STORE_BLOCK,
    OP_INT_DISABLE,
    OP_INT_ALLOW,
    OP_FLAGS_POP,
    OP_TRAP_RETURN,
    OP_IDENT_QUERY,
    OP_MEM_UNCACHED,
    OP_MEM_CACHED
  } port_op_e;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_DWORD
  } port_size_e;

  typedef struct packed {
    port_op_e   op;
    port_size_e size;
    logic [15:0] port;
    logic [31:0] data;
  } port_req_s;

  typedef struct packed {
    logic        req;
    logic        we;
    port_size_e  size;
    logic [15:0] addr;
    logic [31:0] wdata;
  } io_cmd_s;

endpackage : port_chk_pkg

// ### hw/io_port_access_checker.sv
// port-space access checker: privilege, permission map and ordering
//
// How it works
// R1: port and interrupt ops need privilege within threshold
// R2: unprivileged sensitive op faults unless map grants
// R3: threshold lives in the per-task status word
// R4: threshold changes only by pop/return at level 0
// R5: pop alters interrupt flag only when privileged enough
// R6: map located from task area map base field
// R7: privileged protected-mode access skips the map
// R8: unprivileged or legacy mode consults the map
// R9: bit is port mod 8 of byte port/8
// R10: every covered bit tested, any set faults
// R11: two consecutive map bytes fetched per check; here the second is not fetched when it lies past the limit
// R12: software adds all-ones byte after the map
// R13: map bits beyond segment limit count as set
// R14: map base at or past limit means no map
// R15: port writes never sit in a write buffer
// R16: uncached memory accesses leave in program order
// R17: cached reads may pass buffered stores
// R18: port loads and stores wait for pending stores
// R19: serializing op drains all earlier operations
// R20: 64K byte ports, wide access spans neighbours
// R21: failed check suppresses the port bus cycle
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
module io_port_access_checker (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  req_valid_i,
  input  wire port_chk_pkg::port_req_s req_i,
  input  wire logic [1:0]            running_privilege_i,
  input  wire logic                  pending_stores_i,
  output logic                       req_ready_o,
  output logic                       done_o,
  output logic                       fault_o,
  output logic      [31:0]           rdata_o,
  output logic                       mem_req_o,
  output logic      [31:0]           mem_addr_o,
  input  wire logic                  mem_ack_i,
  input  wire logic [7:0]            mem_rdata_i,
  output port_chk_pkg::io_cmd_s      io_cmd_o,
  input  wire logic                  io_ack_i,
  input  wire logic [31:0]           io_rdata_i
);

  typedef enum logic [2:0] {
    S_IDLE,
    S_CHECK,
    S_FETCH0,
    S_FETCH1,
    S_EVAL,
    S_DRAIN,
    S_BUS
  } state_e;

  // register file
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] flags_reg, flags_next;
  logic [31:0] tbase_reg, tbase_next;
  logic [31:0] tlimit_reg, tlimit_next;
  logic [15:0] mapb_reg, mapb_next;
  logic [15:0] fport_reg, fport_next;
  logic [15:0] fcnt_reg, fcnt_next;
  logic        ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;

  // sequencer
  state_e      state_reg, state_next;
  port_chk_pkg::port_req_s cur_reg, cur_next;
  logic [1:0]  priv_reg, priv_next;
  logic [7:0]  b0_reg, b0_next;
  logic [7:0]  b1_reg, b1_next;
  logic        b1_out_reg, b1_out_next;
  logic [31:0] maddr_reg, maddr_next;
  logic        done_reg, done_next;
  logic        fault_reg, fault_next;
  logic [31:0] rdata_reg, rdata_next;

  logic        wb_hit;
  logic        legacy;
  logic [1:0]  thr;
  logic        priv_ok;
  logic        is_port;
  logic        is_store;
  logic        need_map;
  logic        map_absent;
  logic [32:0] off0;
  logic [32:0] off1;
  logic        b0_out;
  logic        b1_out;
  logic [15:0] pair;
  logic [3:0]  covered;
  logic [3:0]  wmask;
  logic        map_hit;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  assign wb_hit      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = rd_reg;
  assign legacy      = ctrl_reg[port_chk_pkg::CTRL_LEGACY_BIT];
  assign thr         = flags_reg[port_chk_pkg::FLAG_THR_HI:
                                 port_chk_pkg::FLAG_THR_LO]; // [R3]
  assign priv_ok     = priv_reg <= thr; // [R1]
  assign is_port     = cur_reg.op inside {port_chk_pkg::OP_LOAD_ONE,
                                          port_chk_pkg::OP_LOAD_BLOCK,
                                          port_chk_pkg::OP_STORE_ONE,
                                          port_chk_pkg::OP_STORE_BLOCK};
  assign is_store    = cur_reg.op inside {port_chk_pkg::OP_STORE_ONE,
                                          port_chk_pkg::OP_STORE_BLOCK};
  assign need_map    = !priv_ok || legacy; // [R7] [R8]
  assign map_absent  = {16'h0000, mapb_reg} >= tlimit_reg; // [R14]
  // byte index is port / 8 from the map base
  assign off0 = {17'h00000, mapb_reg} +
                {20'h00000, cur_reg.port[15:3]}; // [R6] [R9]
  assign off1 = off0 + 33'h0_0000_0001; // [R11]
  assign b0_out = off0 > {1'b0, tlimit_reg}; // [R13]
  assign b1_out = off1 > {1'b0, tlimit_reg}; // [R13]
  assign pair = {b1_reg, b0_reg};

  always_comb begin
    case (cur_reg.size)
      port_chk_pkg::SZ_BYTE:  wmask = 4'h1;
      port_chk_pkg::SZ_WORD:  wmask = 4'h3;
      default:                wmask = 4'hf;
    endcase
  end

  // adjacent port bytes of a wide access
  assign covered = 4'((pair >> cur_reg.port[2:0])); // [R9] [R20]
  assign map_hit = |(covered & wmask); // [R10]

  assign req_ready_o = state_reg == S_IDLE; // [R18]
  assign done_o      = done_reg;
  assign fault_o     = fault_reg;
  assign rdata_o     = rdata_reg;
  assign mem_req_o   = state_reg == S_FETCH0 || state_reg == S_FETCH1;
  assign mem_addr_o  = maddr_reg;
  // port write goes straight out, never buffered
  assign io_cmd_o.req   = state_reg == S_BUS; // [R15] [R21]
  assign io_cmd_o.we    = is_store;
  assign io_cmd_o.size  = cur_reg.size;
  assign io_cmd_o.addr  = cur_reg.port;
  assign io_cmd_o.wdata = cur_reg.data;

  // register file next values
  always_comb begin
    ctrl_next   = ctrl_reg;
    tbase_next  = tbase_reg;
    tlimit_next = tlimit_reg;
    mapb_next   = mapb_reg;
    ack_next    = wb_hit;
    rd_next     = 32'h0000_0000;
    flags_next  = flags_reg;
    if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        port_chk_pkg::OFF_CTRL:
          ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i);
        port_chk_pkg::OFF_FLAGS:
          flags_next = merge(flags_reg, wb_dat_i, wb_sel_i);
        port_chk_pkg::OFF_TBASE:
          tbase_next = merge(tbase_reg, wb_dat_i, wb_sel_i);
        port_chk_pkg::OFF_TLIMIT:
          tlimit_next = merge(tlimit_reg, wb_dat_i, wb_sel_i);
        port_chk_pkg::OFF_MAPB:
          mapb_next = 16'(merge({16'h0000, mapb_reg}, wb_dat_i,
                                wb_sel_i));
        default: ;
      endcase
    end
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        port_chk_pkg::OFF_CTRL:   rd_next = ctrl_reg;
        port_chk_pkg::OFF_FLAGS:  rd_next = flags_reg;
        port_chk_pkg::OFF_TBASE:  rd_next = tbase_reg;
        port_chk_pkg::OFF_TLIMIT: rd_next = tlimit_reg;
        port_chk_pkg::OFF_MAPB:   rd_next = {16'h0000, mapb_reg};
        port_chk_pkg::OFF_STATUS: rd_next = {fcnt_reg, fport_reg};
        default:                  rd_next = 32'h0000_0000;
      endcase
    end
    // instruction effects on the status word override a bus write
    if (state_reg == S_CHECK) begin
      case (cur_reg.op)
        port_chk_pkg::OP_INT_DISABLE: begin
          if (priv_ok) begin
            flags_next[port_chk_pkg::FLAG_IF_BIT] = 1'b0; // [R1]
          end
        end
        port_chk_pkg::OP_INT_ALLOW: begin
          if (priv_ok) begin
            flags_next[port_chk_pkg::FLAG_IF_BIT] = 1'b1; // [R1]
          end
        end
        port_chk_pkg::OP_FLAGS_POP,
        port_chk_pkg::OP_TRAP_RETURN: begin
          flags_next = cur_reg.data;
          if (priv_reg != port_chk_pkg::PRIV_TOP) begin
            flags_next[port_chk_pkg::FLAG_THR_HI:
                       port_chk_pkg::FLAG_THR_LO] = thr; // [R4]
          end
          if (cur_reg.op == port_chk_pkg::OP_FLAGS_POP && !priv_ok) begin
            flags_next[port_chk_pkg::FLAG_IF_BIT] =
              flags_reg[port_chk_pkg::FLAG_IF_BIT]; // [R5]
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg   <= port_chk_pkg::CTRL_RST;
      flags_reg  <= port_chk_pkg::FLAGS_RST;
      tbase_reg  <= port_chk_pkg::TBASE_RST;
      tlimit_reg <= port_chk_pkg::TLIMIT_RST;
      mapb_reg   <= port_chk_pkg::MAPB_RST;
      ack_reg    <= 1'b0;
      rd_reg     <= 32'h0000_0000;
    end else begin
      ctrl_reg   <= ctrl_next;
      flags_reg  <= flags_next;
      tbase_reg  <= tbase_next;
      tlimit_reg <= tlimit_next;
      mapb_reg   <= mapb_next;
      ack_reg    <= ack_next;
      rd_reg     <= rd_next;
    end
  end

  // sequencer next values
  always_comb begin
    state_next  = state_reg;
    cur_next    = cur_reg;
    priv_next   = priv_reg;
    b0_next     = b0_reg;
    b1_next     = b1_reg;
    b1_out_next = b1_out_reg;
    maddr_next  = maddr_reg;
    done_next   = 1'b0;
    fault_next  = 1'b0;
    rdata_next  = rdata_reg;
    fport_next  = fport_reg;
    fcnt_next   = fcnt_reg;
    case (state_reg)
      S_IDLE: begin
        if (req_valid_i) begin
          cur_next   = req_i;
          priv_next  = running_privilege_i;
          state_next = S_CHECK;
        end
      end
      S_CHECK: begin
        if (is_port) begin
          if (!need_map) begin
            state_next = S_DRAIN; // [R7]
          end else if (map_absent || b0_out) begin
            fault_next = 1'b1; // [R2] [R13] [R14] [R21]
            state_next = S_IDLE;
          end else begin
            maddr_next  = tbase_reg + 32'(off0); // [R6]
            b1_out_next = b1_out;
            state_next  = S_FETCH0; // [R8]
          end
        end else begin
          case (cur_reg.op)
            port_chk_pkg::OP_INT_DISABLE,
            port_chk_pkg::OP_INT_ALLOW: begin
              fault_next = !priv_ok; // [R1] [R2]
              done_next  = priv_ok;
              state_next = S_IDLE;
            end
            port_chk_pkg::OP_IDENT_QUERY,
            port_chk_pkg::OP_MEM_UNCACHED: begin
              state_next = S_DRAIN; // [R16] [R19]
            end
            default: begin
              // cached reads may pass buffered stores
              done_next  = 1'b1; // [R17]
              state_next = S_IDLE;
            end
          endcase
        end
      end
      S_FETCH0: begin
        if (mem_ack_i) begin
          b0_next    = mem_rdata_i;
          maddr_next = maddr_reg + 32'h0000_0001; // [R11]
          if (b1_out_reg) begin
            b1_next    = port_chk_pkg::BYTE_ALL_SET; // [R13]
            state_next = S_EVAL;
          end else begin
            state_next = S_FETCH1;
          end
        end
      end
      S_FETCH1: begin
        if (mem_ack_i) begin
          b1_next    = mem_rdata_i; // [R11]
          state_next = S_EVAL;
        end
      end
      S_EVAL: begin
        if (map_hit) begin
          fault_next = 1'b1; // [R10] [R21]
          state_next = S_IDLE;
        end else begin
          state_next = S_DRAIN;
        end
      end
      S_DRAIN: begin
        if (!pending_stores_i) begin // [R18] [R19]
          if (is_port) begin
            state_next = S_BUS;
          end else begin
            done_next  = 1'b1; // [R16]
            state_next = S_IDLE;
          end
        end
      end
      S_BUS: begin
        if (io_ack_i) begin
          // next op held until this store completes
          if (!is_store) begin
            rdata_next = io_rdata_i;
          end
          done_next  = 1'b1; // [R18]
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
    if (fault_next) begin
      fport_next = cur_reg.port;
      fcnt_next  = fcnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg  <= S_IDLE;
      cur_reg    <= '0;
      priv_reg   <= 2'h0;
      b0_reg     <= 8'h00;
      b1_reg     <= 8'h00;
      b1_out_reg <= 1'b0;
      maddr_reg  <= 32'h0000_0000;
      done_reg   <= 1'b0;
      fault_reg  <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      fport_reg  <= 16'h0000;
      fcnt_reg   <= 16'h0000;
    end else begin
      state_reg  <= state_next;
      cur_reg    <= cur_next;
      priv_reg   <= priv_next;
      b0_reg     <= b0_next;
      b1_reg     <= b1_next;
      b1_out_reg <= b1_out_next;
      maddr_reg  <= maddr_next;
      done_reg   <= done_next;
      fault_reg  <= fault_next;
      rdata_reg  <= rdata_next;
      fport_reg  <= fport_next;
      fcnt_reg   <= fcnt_next;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_thr_locked: assert property ( // [R4]
    state_reg == S_CHECK && !(wb_hit && wb_we_i) &&
    priv_reg != port_chk_pkg::PRIV_TOP
    |=> $stable(thr))
    else $error("threshold changed below top privilege");

  chk_if_gate: assert property ( // [R5]
    state_reg == S_CHECK && cur_reg.op == port_chk_pkg::OP_FLAGS_POP &&
    !priv_ok && !(wb_hit && wb_we_i)
    |=> $stable(flags_reg[port_chk_pkg::FLAG_IF_BIT]))
    else $error("interrupt flag popped without privilege");

  chk_map_bypass: assert property ( // [R7]
    state_reg == S_CHECK && is_port && priv_ok && !legacy
    |=> !mem_req_o ##1 !mem_req_o)
    else $error("map consulted for privileged access");

  chk_map_consult: assert property ( // [R8]
    state_reg == S_CHECK && is_port && need_map &&
    !map_absent && !b0_out
    |=> mem_req_o && mem_addr_o == tbase_reg + 32'(off0))
    else $error("map not fetched when required");

  chk_no_map: assert property ( // [R14]
    state_reg == S_CHECK && is_port && !priv_ok && map_absent
    |=> fault_o && !io_cmd_o.req)
    else $error("absent map did not fault");

  chk_second_byte: assert property ( // [R11]
    state_reg == S_FETCH0 && mem_ack_i && !b1_out_reg
    |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 32'h0000_0001)
    else $error("second map byte not fetched");

  chk_load_order: assert property ( // [R18]
    $rose(io_cmd_o.req) |-> !$past(pending_stores_i))
    else $error("port access started over pending stores");

  chk_store_hold: assert property ( // [R18]
    io_cmd_o.req && io_cmd_o.we && io_ack_i
    |=> done_o && !io_cmd_o.req)
    else $error("store completion not reported");

  chk_fault_nobus: assert property ( // [R21]
    fault_o |-> !io_cmd_o.req && !$past(io_cmd_o.req))
    else $error("bus cycle issued on failed check");

  chk_serialize: assert property ( // [R19]
    state_reg == S_DRAIN && cur_reg.op == port_chk_pkg::OP_IDENT_QUERY &&
    pending_stores_i |=> !done_o)
    else $error("serializing op finished over pending stores");

endmodule : io_port_access_checker

// ### tb/port_bus_model.sv
// far-side model: permission map memory and port-space bus
`timescale 1ns/100ps
module port_bus_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  slow_i,
  input  wire logic                  mem_req_i,
  input  wire logic [31:0]           mem_addr_i,
  output logic                       mem_ack_o,
  output logic      [7:0]            mem_rdata_o,
  input  wire port_chk_pkg::io_cmd_s io_cmd_i,
  output logic                       io_ack_o,
  output logic      [31:0]           io_rdata_o
);
  logic [7:0]  map_mem [256];
  logic [7:0]  m_last;
  logic [31:0] p_last, mem_addr_seen, io_addr, io_wdata;
  logic [2:0]  m_cnt, p_cnt, dly;
  logic [2:0]  io_kind;
  int          io_count, mem_count;

  // released lines show the inverse of the last value
  assign mem_rdata_o = mem_ack_o ? m_last : ~m_last;
  assign io_rdata_o  = io_ack_o ? p_last : ~p_last;
  assign dly         = slow_i ? 3'h3 : 3'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'h0;
      io_ack_o  <= 1'h0;
      m_cnt     <= 3'h0;
      p_cnt     <= 3'h0;
      m_last    <= 8'h00;
      p_last    <= 32'h0;
      io_count  <= 0;
      mem_count <= 0;
    end else begin
      mem_ack_o <= 1'h0;
      io_ack_o  <= 1'h0;
      if (mem_req_i && !mem_ack_o) begin
        m_cnt <= m_cnt + 3'h1;
        if (m_cnt >= dly) begin
          mem_ack_o     <= 1'h1;
          m_cnt         <= 3'h0;
          m_last        <= map_mem[mem_addr_i[7:0]];
          mem_addr_seen <= mem_addr_i;
          mem_count     <= mem_count + 1;
        end
      end
      if (io_cmd_i.req && !io_ack_o) begin
        p_cnt <= p_cnt + 3'h1;
        if (p_cnt >= dly) begin
          io_ack_o <= 1'h1;
          p_cnt    <= 3'h0;
          p_last   <= io_cmd_i.we ? io_cmd_i.wdata : {16'ha5a5, io_cmd_i.addr};
          io_addr  <= {16'h0, io_cmd_i.addr};
          io_wdata <= io_cmd_i.wdata;
          io_kind  <= {io_cmd_i.we, io_cmd_i.size};
          io_count <= io_count + 1;
        end
      end
    end
  end
endmodule : port_bus_model

// ### tb/io_port_access_checker_tb.sv
// self-checking bench for the port access checker
`timescale 1ns/100ps
module io_port_access_checker_tb;
  logic                    clk_i, rst_i, slow, f, s;
  logic                    wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]              wb_adr_i, mem_rdata_i;
  logic [3:0]              wb_sel_i;
  logic [31:0]             wb_dat_i, wb_dat_o, rdata_o, mem_addr_o;
  logic [31:0]             io_rdata_i, q;
  logic                    req_valid_i, req_ready_o, done_o, fault_o;
  logic                    pending_stores_i, mem_req_o, mem_ack_i, io_ack_i;
  logic [1:0]              running_privilege_i;
  port_chk_pkg::port_req_s req_i;
  port_chk_pkg::io_cmd_s   io_cmd_o;
  int                      miscompares, n_checks;
  localparam logic [15:0]  MP [11] = '{16'h0029, 16'h0028, 16'h002a, 16'h002f,
    16'h0026, 16'h00b6, 16'h00b7, 16'h00c0, 16'h0029, 16'hffff, 16'h00b8};
  localparam int           MS [11] = '{0, 0, 1, 1, 2, 1, 1, 0, 0, 0, 0};
  localparam int           MR [11] = '{2, 2, 2, 2, 2, 2, 2, 0, 0, 0, 1};
  localparam logic [10:0]  MU = 11'h4ff;
  localparam logic [10:0]  MF = 11'h4d9;

  io_port_access_checker io_port_access_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
    .running_privilege_i(running_privilege_i), .done_o(done_o),
    .pending_stores_i(pending_stores_i), .fault_o(fault_o),
    .rdata_o(rdata_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i), .io_cmd_o(io_cmd_o),
    .io_ack_i(io_ack_i), .io_rdata_i(io_rdata_i));
  port_bus_model port_bus_model_i (
    .clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i),
    .io_cmd_i(io_cmd_o), .io_ack_o(io_ack_i), .io_rdata_o(io_rdata_i));

  initial begin
    clk_i = 1'h0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic timeout();
    miscompares++;
    print_verdict();
  endtask : timeout

  task automatic check(input string n, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] sl,
                    input logic [31:0] d);
    int i;
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'h1) break;
    end
    if (i == 20) timeout();
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 4'hf, 32'h0);
    check("register", q, exp);
  endtask : rd

  task automatic start_op(input port_chk_pkg::port_op_e o, input int sz,
                          input logic [15:0] p, input logic [31:0] d,
                          input logic [1:0] pr);
    int i;
    req_valid_i         <= 1'h1;
    req_i               <= {o, port_chk_pkg::port_size_e'(sz), p, d};
    running_privilege_i <= pr;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (req_ready_o === 1'h1) break;
    end
    if (i == 20) timeout();
    req_valid_i <= 1'h0;
  endtask : start_op

  task automatic finish_op();
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge clk_i);
      if (done_o === 1'h1 || fault_o === 1'h1) break;
    end
    if (i == 100) timeout();
    f = fault_o;
  endtask : finish_op

  task automatic op(input port_chk_pkg::port_op_e o, input int sz,
                    input logic [15:0] p, input logic [31:0] d,
                    input logic [1:0] pr);
    start_op(o, sz, p, d, pr);
    finish_op();
  endtask : op

  task automatic t_regs();
    rd(port_chk_pkg::OFF_CTRL, port_chk_pkg::CTRL_RST);
    rd(port_chk_pkg::OFF_FLAGS, port_chk_pkg::FLAGS_RST);
    rd(port_chk_pkg::OFF_TBASE, port_chk_pkg::TBASE_RST);
    rd(port_chk_pkg::OFF_TLIMIT, port_chk_pkg::TLIMIT_RST);
    rd(port_chk_pkg::OFF_MAPB, {16'h0, port_chk_pkg::MAPB_RST});
    wb(1'h1, 8'h18, 4'hf, 32'hffff_ffff);
    rd(8'h18, 32'h0);
    wb(1'h1, port_chk_pkg::OFF_TLIMIT, 4'h1, 32'hffff_ffff);
    rd(port_chk_pkg::OFF_TLIMIT, 32'h0000_00ff);
    wb(1'h1, port_chk_pkg::OFF_TLIMIT, 4'hf, 32'h0000_0067);
    op(port_chk_pkg::OP_LOAD_ONE, 0, 16'h0028, 32'h0, 2'h3);
    check("absent map fault", f, 1'h1);
    check("map reads", port_bus_model_i.mem_count, 32'h0);
    check("port cycles", port_bus_model_i.io_count, 32'h0);
    rd(port_chk_pkg::OFF_STATUS, 32'h0001_0028);
    wb(1'h1, port_chk_pkg::OFF_STATUS, 4'hf, 32'h0);
    rd(port_chk_pkg::OFF_STATUS, 32'h0001_0028);
  endtask : t_regs

  task automatic t_map();
    int k, c, m;
    for (k = 0; k < 256; k++) begin
      port_bus_model_i.map_mem[k] = 8'h00;
    end
    port_bus_model_i.map_mem[8'h6d] = 8'h02;
    port_bus_model_i.map_mem[8'h6e] = 8'h01;
    port_bus_model_i.map_mem[8'h7f] = 8'hff;
    wb(1'h1, port_chk_pkg::OFF_TLIMIT, 4'hf, 32'h0000_007f);
    for (k = 0; k < 11; k++) begin
      c = port_bus_model_i.io_count;
      m = port_bus_model_i.mem_count;
      op(port_chk_pkg::OP_LOAD_ONE, MS[k], MP[k], 32'h0, {MU[k], MU[k]});
      check("fault", f, MF[k]);
      c = port_bus_model_i.io_count - c;
      m = port_bus_model_i.mem_count - m;
      check("map reads", m, MR[k]);
      check("port cycles", c, {31'h0, !MF[k]});
      if (!MF[k]) begin
        check("port addr", port_bus_model_i.io_addr, {16'h0, MP[k]});
        check("port kind", port_bus_model_i.io_kind, 32'(MS[k]));
        check("load data", rdata_o, {16'ha5a5, MP[k]});
      end
    end
    check("map addr", port_bus_model_i.mem_addr_seen, 32'h7f);
    wb(1'h1, port_chk_pkg::OFF_CTRL, 4'hf, 32'h1);
    op(port_chk_pkg::OP_LOAD_ONE, 0, 16'h0029, 32'h0, 2'h0);
    check("legacy fault", f, 1'h1);
    op(port_chk_pkg::OP_LOAD_ONE, 0, 16'h0028, 32'h0, 2'h0);
    check("legacy grant", f, 1'h0);
    wb(1'h1, port_chk_pkg::OFF_CTRL, 4'hf, 32'h0);
  endtask : t_map

  task automatic t_flags();
    op(port_chk_pkg::OP_FLAGS_POP, 0, 16'h0, 32'h0000_3202, 2'h3);
    check("pop fault", f, 1'h0);
    rd(port_chk_pkg::OFF_FLAGS, 32'h0000_0002);
    op(port_chk_pkg::OP_INT_DISABLE, 0, 16'h0, 32'h0, 2'h3);
    check("cli fault", f, 1'h1);
    op(port_chk_pkg::OP_INT_ALLOW, 0, 16'h0, 32'h0, 2'h0);
    check("sti fault", f, 1'h0);
    op(port_chk_pkg::OP_FLAGS_POP, 0, 16'h0, 32'h0000_3202, 2'h0);
    rd(port_chk_pkg::OFF_FLAGS, 32'h0000_3202);
    op(port_chk_pkg::OP_FLAGS_POP, 0, 16'h0, 32'h0000_0002, 2'h2);
    rd(port_chk_pkg::OFF_FLAGS, 32'h0000_3002);
    op(port_chk_pkg::OP_INT_DISABLE, 0, 16'h0, 32'h0, 2'h3);
    check("cli fault", f, 1'h0);
    op(port_chk_pkg::OP_TRAP_RETURN, 0, 16'h0, 32'h0000_0202, 2'h0);
    rd(port_chk_pkg::OFF_FLAGS, 32'h0000_0202);
    wb(1'h1, port_chk_pkg::OFF_FLAGS, 4'hf, 32'h0000_1002);
    op(port_chk_pkg::OP_LOAD_ONE, 0, 16'h0029, 32'h0, 2'h1);
    check("task threshold", f, 1'h0);
    op(port_chk_pkg::OP_LOAD_ONE, 0, 16'h0029, 32'h0, 2'h2);
    check("task threshold", f, 1'h1);
    wb(1'h1, port_chk_pkg::OFF_FLAGS, 4'hf, 32'h0000_0002);
  endtask : t_flags

  task automatic t_order();
    port_chk_pkg::port_op_e oo [5];
    int k;
    oo = '{port_chk_pkg::OP_STORE_ONE, port_chk_pkg::OP_LOAD_ONE,
           port_chk_pkg::OP_IDENT_QUERY, port_chk_pkg::OP_MEM_UNCACHED,
           port_chk_pkg::OP_MEM_CACHED};
    for (k = 0; k < 5; k++) begin
      pending_stores_i <= 1'h1;
      start_op(oo[k], 1, 16'h0040, 32'hcafe_0123, 2'h0);
      s = 1'h0;
      repeat (8) begin
        @(posedge clk_i);
        if (done_o === 1'h1 || io_cmd_o.req === 1'h1) s = 1'h1;
      end
      check("early start", s, {31'h0, k == 4});
      pending_stores_i <= 1'h0;
      if (k < 4) begin
        finish_op();
        check("fault", f, 1'h0);
      end
      if (k == 0) begin
        check("store data", port_bus_model_i.io_wdata, 32'hcafe_0123);
        check("store kind", port_bus_model_i.io_kind, 32'h5);
      end
    end
  endtask : t_order

  initial begin
    miscompares         = 0;
    n_checks            = 0;
    rst_i               = 1'h1;
    slow                = 1'h0;
    wb_cyc_i            = 1'h0;
    wb_stb_i            = 1'h0;
    wb_we_i             = 1'h0;
    wb_adr_i            = 8'h00;
    wb_sel_i            = 4'h0;
    wb_dat_i            = 32'h0;
    req_valid_i         = 1'h0;
    req_i               = '0;
    running_privilege_i = 2'h0;
    pending_stores_i    = 1'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_regs();
    t_map();
    slow <= 1'h1;
    t_map();
    t_flags();
    t_order();
    print_verdict();
  end
endmodule : io_port_access_checker_tb
